// ==== verilog/tlm_pkg.sv ====
/*
  Constants, line timing and mode encoding for the terminal line-mode controller.
  Assumes a 10 MHz system clock and a character-serial line driven at the basic rate.
*/
// Notes on behaviour
// - After power-up the terminal sits in control-receive mode before doing anything else on the line.
// - In control-receive mode incoming characters are examined and only the bid character acts.
// - A bid character received in control-receive mode puts the terminal in receive mode for the message.
// - The operator bid key moves the terminal to transmit mode, then the bid character is sent.
// - In transmit mode each keyed character is sent as text in the order keyed.
// - The operator end key sends the end-of-transmission character, then returns to control-receive mode.
// - A received end-of-transmission character ends receive mode and returns to control-receive mode.
// - With both ends back in control-receive mode either terminal may bid and become the sender.
// - Only one terminal transmits at a time; a terminal stays out of transmit mode while the line is held.
// - Without addressing, every attached terminal receives whatever message is on the line.
// - In local mode the keyboard goes only to the own printer and the line is left alone.
// - A local/communicate selector chooses off-line typing or on-line line control.
// - The basic line runs at 14.8 characters per second, 134.5 bits per second.

package tlm_pkg;

  localparam int unsigned TLM_CLK_HZ       = 10_000_000;
  localparam int unsigned TLM_LINE_BPS_X10 = 1345;  // 134.5 bit/s
  localparam int unsigned TLM_CHAR_PS_X10  = 148;   // 14.8 char/s
  localparam int unsigned TLM_BIT_CYCLES   = (TLM_CLK_HZ * 10) / TLM_LINE_BPS_X10;
  localparam int unsigned TLM_DATA_W       = 7;

  localparam logic [6:0]  TLM_BID_CODE     = 7'h44;
  localparam logic [6:0]  TLM_EOT_CODE     = 7'h43;

  localparam logic        TLM_BEGIN_BIT    = 1'b0;
  localparam logic        TLM_END_BIT      = 1'b1;

  typedef enum logic [2:0] {
    TLM_CONTROL_RECEIVE = 3'h0,
    TLM_OFFLINE_TYPING  = 3'h1,
    TLM_TX_BID          = 3'h2,
    TLM_TX_TEXT         = 3'h3,
    TLM_TX_EOT          = 3'h4,
    TLM_TX_DRAIN        = 3'h5,
    TLM_RX_TEXT         = 3'h6
  } tlm_mode_type;

endpackage : tlm_pkg

// ==== verilog/tlm_line_framer.sv ====
/*
  Character framer: one start-framed, end-framed character out and in, least bit first.
  Assumes the line input is synchronous to clk and BIT_CYCLES is at least 2.
*/
`timescale 1ns/100ps

module tlm_line_framer
  import tlm_pkg::*;
#(
  parameter int unsigned DATA_W     = TLM_DATA_W,
  parameter int unsigned BIT_CYCLES = TLM_BIT_CYCLES
) (
  input  wire logic              clk,
  input  wire logic              rstn,
  input  wire logic              tx_start,
  input  wire logic [DATA_W-1:0] tx_data,
  input  wire logic              line_in_bit,
  output logic                   tx_busy,
  output logic                   tx_line,
  output logic                   rx_valid,
  output logic      [DATA_W-1:0] rx_data
);

  localparam int CW = $clog2(BIT_CYCLES + 1);
  localparam int FW = $clog2(DATA_W + 3);
  localparam logic [CW-1:0] BIT_LAST  = CW'(BIT_CYCLES - 1);
  localparam logic [CW-1:0] HALF_LAST = CW'(BIT_CYCLES / 2 - 1);
  localparam logic [FW-1:0] TX_BITS   = FW'(DATA_W + 1);
  localparam logic [FW-1:0] RX_BITS   = FW'(DATA_W + 2);

  logic [DATA_W:0]   tx_shift;
  logic [CW-1:0]     tx_cnt;
  logic [FW-1:0]     tx_left;
  logic              rx_prev;
  logic              rx_act;
  logic [CW-1:0]     rx_cnt;
  logic [FW-1:0]     rx_left;
  logic [DATA_W-1:0] rx_shift;

  // Transmit: begin bit, data least bit first, end bit
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tx_busy  <= 1'b0;
      tx_line  <= TLM_END_BIT;
      tx_shift <= '1;
      tx_cnt   <= '0;
      tx_left  <= '0;
    end else if (tx_start && !tx_busy) begin
      tx_busy  <= 1'b1;
      tx_line  <= TLM_BEGIN_BIT;
      tx_shift <= {TLM_END_BIT, tx_data};
      tx_cnt   <= BIT_LAST;
      tx_left  <= TX_BITS;
    end else if (tx_busy) begin
      if (tx_cnt != '0) begin
        tx_cnt <= tx_cnt - 1'b1;
      end else if (tx_left != '0) begin
        tx_line  <= tx_shift[0];
        tx_shift <= {1'b1, tx_shift[DATA_W:1]};
        tx_left  <= tx_left - 1'b1;
        tx_cnt   <= BIT_LAST;
      end else begin
        tx_busy <= 1'b0;
      end
    end
  end

  // Receive: sample mid-bit, drop frames with a bad begin or end bit
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rx_prev  <= TLM_END_BIT;
      rx_act   <= 1'b0;
      rx_cnt   <= '0;
      rx_left  <= '0;
      rx_shift <= '0;
      rx_valid <= 1'b0;
      rx_data  <= '0;
    end else begin
      rx_prev  <= line_in_bit;
      rx_valid <= 1'b0;
      if (!rx_act) begin
        if (rx_prev && (line_in_bit == TLM_BEGIN_BIT)) begin
          rx_act  <= 1'b1;
          rx_cnt  <= HALF_LAST;
          rx_left <= RX_BITS;
        end
      end else if (rx_cnt != '0) begin
        rx_cnt <= rx_cnt - 1'b1;
      end else begin
        rx_cnt  <= BIT_LAST;
        rx_left <= rx_left - 1'b1;
        if (rx_left == RX_BITS) begin
          if (line_in_bit != TLM_BEGIN_BIT) begin
            rx_act <= 1'b0;
          end
        end else if (rx_left == FW'(1)) begin
          rx_act <= 1'b0;
          if (line_in_bit == TLM_END_BIT) begin
            rx_valid <= 1'b1;
            rx_data  <= rx_shift;
          end
        end else begin
          rx_shift <= {line_in_bit, rx_shift[DATA_W-1:1]};
        end
      end
    end
  end

  property p_frame_begin;
    @(posedge clk) disable iff (!rstn)
      (tx_start && !tx_busy) |=> (tx_busy && tx_line == TLM_BEGIN_BIT) [*2];
  endproperty
  a_frame_begin: assert property (p_frame_begin) else $error("begin bit not driven");

  property p_frame_end;
    @(posedge clk) disable iff (!rstn)
      rx_valid |-> $past(line_in_bit) == TLM_END_BIT;
  endproperty
  a_frame_end: assert property (p_frame_end) else $error("character accepted without end bit");

endmodule : tlm_line_framer

// ==== verilog/tlm_line_control.sv ====
/*
  Line-mode sequencer of a character-serial communication terminal: control-receive,
  transmit, receive and off-line typing. Assumes keys, selector and line input are
  synchronous to clk, and that the printer takes one character per cycle.
*/
`timescale 1ns/100ps

module tlm_line_control
  import tlm_pkg::*;
#(
  parameter int unsigned      DATA_W     = TLM_DATA_W,
  parameter int unsigned      BIT_CYCLES = TLM_BIT_CYCLES,
  parameter logic [DATA_W-1:0] BID_CODE  = TLM_BID_CODE,
  parameter logic [DATA_W-1:0] EOT_CODE  = TLM_EOT_CODE
) (
  input  wire logic              clk,
  input  wire logic              rstn,
  input  wire logic              online_link_mode,
  input  wire logic              bid_key,
  input  wire logic              eot_key,
  input  wire logic              key_valid,
  input  wire logic [DATA_W-1:0] key_data,
  output logic                   key_ready,
  input  wire logic              line_in_bit,
  output logic                   line_out_bit,
  output logic                   print_valid,
  output logic      [DATA_W-1:0] print_data,
  output tlm_mode_type           mode
);

  function automatic logic is_code(input logic [DATA_W-1:0] d, input logic [DATA_W-1:0] c);
    is_code = (d == c);
  endfunction : is_code

  tlm_mode_type      next_mode;
  logic              next_key_ready;
  logic              tx_start;
  logic [DATA_W-1:0] tx_data;
  logic              tx_busy;
  logic              tx_line;
  logic              rx_valid;
  logic [DATA_W-1:0] rx_data;
  logic              tx_free;
  logic              key_acc;
  logic              bid_seen;
  logic              eot_seen;
  logic              first_q;

  tlm_line_framer #(
    .DATA_W     (DATA_W),
    .BIT_CYCLES (BIT_CYCLES)
  ) u_framer (
    .clk         (clk),
    .rstn        (rstn),
    .tx_start    (tx_start),
    .tx_data     (tx_data),
    .line_in_bit (line_in_bit),
    .tx_busy     (tx_busy),
    .tx_line     (tx_line),
    .rx_valid    (rx_valid),
    .rx_data     (rx_data)
  );

  assign tx_free  = !tx_start && !tx_busy;
  assign key_acc  = key_valid && key_ready;
  assign bid_seen = rx_valid && is_code(rx_data, BID_CODE);
  assign eot_seen = rx_valid && is_code(rx_data, EOT_CODE);

  // Mode sequencing
  always_comb begin
    next_mode = mode;
    unique case (mode)
      TLM_OFFLINE_TYPING: begin
        if (online_link_mode) next_mode = TLM_CONTROL_RECEIVE;
      end
      TLM_CONTROL_RECEIVE: begin
        if (!online_link_mode) begin
          next_mode = TLM_OFFLINE_TYPING;
        end else if (bid_seen) begin
          next_mode = TLM_RX_TEXT;
        end else if (bid_key) begin
          next_mode = TLM_TX_BID;
        end
      end
      TLM_TX_BID: begin
        if (tx_free) next_mode = TLM_TX_TEXT;
      end
      TLM_TX_TEXT: begin
        if (eot_key) next_mode = TLM_TX_EOT;
      end
      TLM_TX_EOT: begin
        if (tx_free) next_mode = TLM_TX_DRAIN;
      end
      TLM_TX_DRAIN: begin
        if (tx_free) next_mode = TLM_CONTROL_RECEIVE;
      end
      TLM_RX_TEXT: begin
        if (!online_link_mode) begin
          next_mode = TLM_OFFLINE_TYPING;
        end else if (eot_seen) begin
          next_mode = TLM_CONTROL_RECEIVE;
        end
      end
      default: next_mode = TLM_CONTROL_RECEIVE;
    endcase
  end

  // Keys are taken off-line, or in transmit text while the framer is free
  always_comb begin
    next_key_ready = (next_mode == TLM_OFFLINE_TYPING) ||
                     (mode == TLM_TX_TEXT && next_mode == TLM_TX_TEXT && tx_free && !key_acc);
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mode <= TLM_CONTROL_RECEIVE;
    end else begin
      mode <= next_mode;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      key_ready <= 1'b0;
    end else begin
      key_ready <= next_key_ready;
    end
  end

  // Character launch toward the framer
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tx_start <= 1'b0;
      tx_data  <= '0;
    end else begin
      tx_start <= 1'b0;
      if (mode == TLM_TX_BID && tx_free) begin
        tx_start <= 1'b1;
        tx_data  <= BID_CODE;
      end else if (mode == TLM_TX_TEXT && key_acc) begin
        tx_start <= 1'b1;
        tx_data  <= key_data;
      end else if (mode == TLM_TX_EOT && tx_free) begin
        tx_start <= 1'b1;
        tx_data  <= EOT_CODE;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      line_out_bit <= TLM_END_BIT;
    end else begin
      line_out_bit <= tx_line;
    end
  end

  // Printer: local typing, echo of sent text, every received text character
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      print_valid <= 1'b0;
      print_data  <= '0;
    end else begin
      print_valid <= 1'b0;
      if (key_acc && (mode == TLM_OFFLINE_TYPING || mode == TLM_TX_TEXT)) begin
        print_valid <= 1'b1;
        print_data  <= key_data;
      end else if (mode == TLM_RX_TEXT && online_link_mode && rx_valid && !eot_seen) begin
        print_valid <= 1'b1;
        print_data  <= rx_data;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      first_q <= 1'b1;
    end else begin
      first_q <= 1'b0;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_bid_launch;
    (mode == TLM_TX_BID) ##1 (tx_start && tx_data == BID_CODE && mode == TLM_TX_TEXT);
  endsequence

  sequence s_eot_close;
    (mode == TLM_TX_DRAIN && tx_start && tx_data == EOT_CODE);
  endsequence

  property p_power_up;
    first_q |-> mode == TLM_CONTROL_RECEIVE;
  endproperty
  a_power_up: assert property (p_power_up) else $error("not in control-receive after reset");

  property p_bid_rx;
    (mode == TLM_CONTROL_RECEIVE && online_link_mode && bid_seen) |=> mode == TLM_RX_TEXT;
  endproperty
  a_bid_rx: assert property (p_bid_rx) else $error("received bid did not enter receive");

  property p_bid_key;
    (mode == TLM_CONTROL_RECEIVE && online_link_mode && bid_key && !bid_seen) |=> s_bid_launch;
  endproperty
  a_bid_key: assert property (p_bid_key) else $error("bid key did not launch bid");

  property p_text_send;
    (mode == TLM_TX_TEXT && key_acc) |=> tx_start && tx_data == $past(key_data);
  endproperty
  a_text_send: assert property (p_text_send) else $error("keyed character not sent");

  property p_eot_send;
    (mode == TLM_TX_EOT && tx_free) |=> s_eot_close;
  endproperty
  a_eot_send: assert property (p_eot_send) else $error("end character not sent");

  property p_drain_done;
    (mode == TLM_TX_DRAIN && tx_free) |=> mode == TLM_CONTROL_RECEIVE;
  endproperty
  a_drain_done: assert property (p_drain_done) else $error("no return to control-receive");

  property p_eot_rx;
    (mode == TLM_RX_TEXT && online_link_mode && eot_seen) |=> mode == TLM_CONTROL_RECEIVE && !print_valid;
  endproperty
  a_eot_rx: assert property (p_eot_rx) else $error("received end did not close receive");

  property p_line_free;
    (mode == TLM_CONTROL_RECEIVE) |-> !tx_busy && !tx_start;
  endproperty
  a_line_free: assert property (p_line_free) else $error("line held in control-receive");

  property p_one_sender;
    tx_start |-> mode inside {TLM_TX_TEXT, TLM_TX_EOT, TLM_TX_DRAIN};
  endproperty
  a_one_sender: assert property (p_one_sender) else $error("transmission outside transmit mode");

  property p_bid_yield;
    (mode == TLM_CONTROL_RECEIVE && online_link_mode && bid_seen && bid_key) |=> mode == TLM_RX_TEXT;
  endproperty
  a_bid_yield: assert property (p_bid_yield) else $error("local bid taken on held line");

  property p_rx_print;
    (mode == TLM_RX_TEXT && online_link_mode && rx_valid && !eot_seen)
      |=> print_valid && print_data == $past(rx_data);
  endproperty
  a_rx_print: assert property (p_rx_print) else $error("received text not printed");

  property p_local_type;
    (mode == TLM_OFFLINE_TYPING && key_acc) |=> print_valid && print_data == $past(key_data) && !tx_start;
  endproperty
  a_local_type: assert property (p_local_type) else $error("local key not typed locally");

  property p_local_sel;
    (mode inside {TLM_CONTROL_RECEIVE, TLM_RX_TEXT} && !online_link_mode) |=> mode == TLM_OFFLINE_TYPING;
  endproperty
  a_local_sel: assert property (p_local_sel) else $error("local selection ignored");

endmodule : tlm_line_control

// ==== verif/tlm_far_terminal.sv ====
/*
  Far-end terminal model: frames characters onto the line and collects what the device sends.
  Assumes an idle-high serial line synchronous to clk and the same bit period as the device.
*/
`timescale 1ns/100ps

module tlm_far_terminal
  import tlm_pkg::*;
#(
  parameter int unsigned DATA_W     = TLM_DATA_W,
  parameter int unsigned BIT_CYCLES = TLM_BIT_CYCLES
) (
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic line_out_bit,
  output logic      line_in_bit
);
  logic [DATA_W-1:0] rx_q[$];
  logic [DATA_W-1:0] shift;
  logic              frame_ok;

  initial line_in_bit = 1'b1;

  // One framed character, least bit first
  task automatic send_char(input logic [DATA_W-1:0] c);
    @(posedge clk);
    #10;
    line_in_bit = TLM_BEGIN_BIT;
    repeat (BIT_CYCLES) @(posedge clk);
    for (int i = 0; i < DATA_W; i++) begin
      #10;
      line_in_bit = c[i];
      repeat (BIT_CYCLES) @(posedge clk);
    end
    #10;
    line_in_bit = TLM_END_BIT;
    repeat (BIT_CYCLES) @(posedge clk);
  endtask : send_char

  // Bit-centre sampling of the device's line output
  always begin : rx_loop
    @(posedge clk);
    if (rstn === 1'b1 && line_out_bit === 1'b0) begin
      repeat (BIT_CYCLES / 2) @(posedge clk);
      frame_ok = (line_out_bit === TLM_BEGIN_BIT);
      for (int i = 0; i < DATA_W; i++) begin
        repeat (BIT_CYCLES) @(posedge clk);
        shift[i] = line_out_bit;
      end
      repeat (BIT_CYCLES) @(posedge clk);
      if (frame_ok && line_out_bit === TLM_END_BIT) begin
        rx_q.push_back(shift);
      end
    end
  end

endmodule : tlm_far_terminal

// ==== verif/tlm_line_control_test.sv ====
/*
  Self-checking bench for the line-mode sequencer, facing a far-end terminal model.
  Assumes a short bit period so that each frame takes a few dozen cycles.
*/
`timescale 1ns/100ps

module tlm_line_control_test
  import tlm_pkg::*;
;
  localparam int unsigned DW   = TLM_DATA_W;
  localparam int unsigned BITC = 8;

  logic              clk;
  logic              rstn;
  logic              online_link_mode;
  logic              bid_key;
  logic              eot_key;
  logic              key_valid;
  logic [DW-1:0]     key_data;
  logic              key_ready;
  logic              line_in_bit;
  logic              line_out_bit;
  logic              print_valid;
  logic [DW-1:0]     print_data;
  tlm_mode_type      mode;
  logic [DW-1:0]     print_q[$];
  int                failures;
  int                samples_checked;

  tlm_line_control #(.DATA_W(DW), .BIT_CYCLES(BITC), .BID_CODE(TLM_BID_CODE), .EOT_CODE(TLM_EOT_CODE)) uut (
    .clk(clk), .rstn(rstn), .online_link_mode(online_link_mode), .bid_key(bid_key), .eot_key(eot_key),
    .key_valid(key_valid), .key_data(key_data), .key_ready(key_ready), .line_in_bit(line_in_bit),
    .line_out_bit(line_out_bit), .print_valid(print_valid), .print_data(print_data), .mode(mode)
  );

  tlm_far_terminal #(.DATA_W(DW), .BIT_CYCLES(BITC)) partner (
    .clk(clk), .rstn(rstn), .line_out_bit(line_out_bit), .line_in_bit(line_in_bit)
  );

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  always @(posedge clk) begin
    if (print_valid === 1'b1) print_q.push_back(print_data);
  end

  task automatic check_val(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask : check_val

  task automatic tick;
    @(posedge clk);
    #10;
  endtask : tick

  task automatic wait_mode(input tlm_mode_type m, input int limit);
    int n;
    n = 0;
    while (mode !== m && n < limit) begin
      tick();
      n++;
    end
    check_val(8'(mode), 8'(m));
  endtask : wait_mode

  task automatic key_char(input logic [DW-1:0] c);
    int  n;
    logic took;
    took = 1'b0;
    tick();
    key_valid = 1'b1;
    key_data  = c;
    for (n = 0; n < 3000 && !took; n++) begin
      @(posedge clk);
      took = (key_ready === 1'b1);
    end
    #10;
    key_valid = 1'b0;
    check_val(8'(took), 8'h01);
  endtask : key_char

  task automatic t_reset;
    check_val(8'(mode), 8'(TLM_CONTROL_RECEIVE));
    check_val(8'(line_out_bit), 8'h01);
    tick();
    check_val(8'(mode), 8'(TLM_CONTROL_RECEIVE));
  endtask : t_reset

  task automatic t_offline;
    tick();
    online_link_mode = 1'b0;
    wait_mode(TLM_OFFLINE_TYPING, 4);
    print_q.delete();
    key_char(7'h31);
    key_char(7'h32);
    tick();
    tick();
    check_val(8'(print_q.size()), 8'h02);
    check_val(8'(print_q[0]), 8'h31);
    check_val(8'(print_q[1]), 8'h32);
    partner.send_char(TLM_BID_CODE);
    repeat (4) tick();
    check_val(8'(mode), 8'(TLM_OFFLINE_TYPING));
    check_val(8'(print_q.size()), 8'h02);
    check_val(8'(partner.rx_q.size()), 8'h00);
    online_link_mode = 1'b1;
    wait_mode(TLM_CONTROL_RECEIVE, 4);
  endtask : t_offline

  task automatic t_receive;
    print_q.delete();
    partner.send_char(7'h41);
    repeat (4) tick();
    check_val(8'(mode), 8'(TLM_CONTROL_RECEIVE));
    check_val(8'(print_q.size()), 8'h00);
    // Local bid key held across the edge at which the received bid is decoded
    fork
      partner.send_char(TLM_BID_CODE);
      begin
        repeat (BITC * 8 + BITC / 2 + 2) @(posedge clk);
        #10;
        bid_key = 1'b1;
        @(posedge clk);
        #10;
        bid_key = 1'b0;
      end
    join
    wait_mode(TLM_RX_TEXT, 20);
    print_q.delete();
    tick();
    key_valid = 1'b1;
    key_data  = 7'h58;
    tick();
    tick();
    check_val(8'(mode), 8'(TLM_RX_TEXT));
    check_val(8'(key_ready), 8'h00);
    key_valid = 1'b0;
    // Back-to-back frames, then the end character
    partner.send_char(7'h55);
    partner.send_char(7'h2A);
    partner.send_char(TLM_EOT_CODE);
    wait_mode(TLM_CONTROL_RECEIVE, 20);
    check_val(8'(print_q.size()), 8'h02);
    check_val(8'(print_q[0]), 8'h55);
    check_val(8'(print_q[1]), 8'h2A);
  endtask : t_receive

  // Local selection in mid-reception abandons the message
  task automatic t_abandon;
    partner.send_char(TLM_BID_CODE);
    wait_mode(TLM_RX_TEXT, 20);
    tick();
    online_link_mode = 1'b0;
    wait_mode(TLM_OFFLINE_TYPING, 4);
    online_link_mode = 1'b1;
    wait_mode(TLM_CONTROL_RECEIVE, 4);
  endtask : t_abandon

  task automatic t_send;
    partner.rx_q.delete();
    tick();
    bid_key = 1'b1;
    tick();
    bid_key = 1'b0;
    check_val(8'(mode), 8'(TLM_TX_BID));
    tick();
    check_val(8'(mode), 8'(TLM_TX_TEXT));
    print_q.delete();
    key_char(7'h21);
    key_char(7'h7E);
    // End key while the last character is still pending
    eot_key = 1'b1;
    tick();
    eot_key = 1'b0;
    wait_mode(TLM_CONTROL_RECEIVE, 400);
    repeat (2) tick();
    check_val(8'(partner.rx_q.size()), 8'h04);
    check_val(8'(partner.rx_q[0]), 8'(TLM_BID_CODE));
    check_val(8'(partner.rx_q[1]), 8'h21);
    check_val(8'(partner.rx_q[2]), 8'h7E);
    check_val(8'(partner.rx_q[3]), 8'(TLM_EOT_CODE));
    check_val(8'(print_q[0]), 8'h21);
    check_val(8'(print_q[1]), 8'h7E);
  endtask : t_send

  task automatic give_verdict;
    $display("checks=%0d failures=%0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : give_verdict

  initial begin
    #(30000 * 100);
    failures++;
    give_verdict();
  end

  initial begin
    failures         = 0;
    samples_checked  = 0;
    rstn             = 1'b0;
    online_link_mode = 1'b1;
    bid_key          = 1'b0;
    eot_key          = 1'b0;
    key_valid        = 1'b0;
    key_data         = '0;
    repeat (8) @(posedge clk);
    #10;
    rstn = 1'b1;
    t_reset();
    t_offline();
    t_receive();
    t_abandon();
    t_send();
    give_verdict();
  end

endmodule : tlm_line_control_test
